// File: hw/pwmg_defs.vh
`ifndef PWMG_DEFS_VH
`define PWMG_DEFS_VH

// Register byte offsets
`define PWMG_OFS_MASTER_DUTY    8'h00
`define PWMG_OFS_CONTROL        8'h04
`define PWMG_OFS_PRIMARY_DUTY   8'h08
`define PWMG_OFS_SECONDARY_DUTY 8'h0c
`define PWMG_OFS_LOCAL_PERIOD   8'h10
`define PWMG_OFS_STATUS         8'h14

// Control register bit positions
`define PWMG_BIT_FAULT_PEND     15
`define PWMG_BIT_CURLIM_PEND    14
`define PWMG_BIT_TRIG_PEND      13
`define PWMG_BIT_FAULT_IEN      12
`define PWMG_BIT_CURLIM_IEN     11
`define PWMG_BIT_TRIG_IEN       10
`define PWMG_BIT_LOCAL_PERIOD   9
`define PWMG_BIT_SHARED_DUTY    8
`define PWMG_BIT_DBC_HI         7
`define PWMG_BIT_DBC_LO         6
`define PWMG_BIT_DBC_POL        5
`define PWMG_BIT_TB_SELECT      3
`define PWMG_BIT_CENTER         2
`define PWMG_BIT_EXT_RESET      1
`define PWMG_BIT_IMMEDIATE      0

// Writable control bits (pending flags and bit 4 are not)
`define PWMG_CTL_WMASK          16'h1fef
`define PWMG_RST_VALUE          16'h0000

// Dead-time control encodings
`define PWMG_DBC_POSITIVE       2'b00
`define PWMG_DBC_NEGATIVE       2'b01
`define PWMG_DBC_OFF            2'b10
`define PWMG_DBC_COMP           2'b11

// Output mode encodings
`define PWMG_MODE_COMPL         2'b00
`define PWMG_MODE_REDUNDANT     2'b01
`define PWMG_MODE_PUSHPULL      2'b10
`define PWMG_MODE_INDEP         2'b11

// Duty limits and resolution
`define PWMG_MIN_PULSE          16'h0009
`define PWMG_COARSE_MASK        16'hfff8
`define PWMG_ZONE_NS            40
`define PWMG_CLK_NS             10
`define PWMG_ZONE_CYC           (`PWMG_ZONE_NS / `PWMG_CLK_NS)

`endif

// File: hw/pwmg_edge_adj.v
`timescale 1ns/100ps
`default_nettype none

// Delays the rising edge (shorten) or the falling edge (lengthen)
// of one output by DEAD_CYC - 1 clock cycles.
module pwmg_edge_adj #(
  parameter DEAD_CYC = 2
) (
  input  wire  clk_i,
  input  wire  rst_n_i,
  input  wire  raw_i,
  input  wire  shorten_i,
  input  wire  lengthen_i,
  output reg   out_o
);

  reg  [7:0] wait_reg;
  reg  [7:0] wait_next;
  reg        out_next;

  localparam [7:0] LAST = DEAD_CYC - 1;

  always @*
  begin
    wait_next = 8'h00;
    out_next  = out_o;
    if (raw_i && !out_o)
    begin
      if (shorten_i && wait_reg < LAST)
        wait_next = wait_reg + 8'h01;
      else
        out_next = 1'b1;
    end
    else if (!raw_i && out_o)
    begin
      if (lengthen_i && wait_reg < LAST)
        wait_next = wait_reg + 8'h01;
      else
        out_next = 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_reg <= 8'h00;
      out_o    <= 1'b0;
    end
    else
    begin
      wait_reg <= wait_next;
      out_o    <= out_next;
    end
  end

endmodule // pwmg_edge_adj

`default_nettype wire

// File: hw/pwmg_top.v
// Operation
// - Duty limited to 0x0009 .. period minus 0x0009; code passes zero duty as zero
// - Coarser duty steps within 40 ns zone
// - Fault pending set; cleared by disabling enable
// - Current-limit pending set; cleared by disabling enable
// - Trigger pending set when enabled; disable clears
// - Local period select picks own period
// - Shared duty select picks master duty
// - Center alignment needs local period select
// - Center mode drops three duty/period LSBs
// - Dead-time field selects positive/negative/off/compensation; code applies negative in complementary mode only
// - Compensation polarity only matters in compensation
// - Compensation input and polarity choose shortened output
// - Time base select picks secondary time base
// - External reset: current limit restarts local time base
// - Immediate update or period-synchronised duty load
// - Primary duty drives both outputs unless independent
// - Secondary duty drives low output when independent
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_defs.vh"

module pwmg_top #(
  parameter DEAD_CYC       = 2,
  parameter SEC_TB_PRESENT = 1
) (
  input  wire        MCLK_I,
  input  wire        RST_N_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output reg         PSLVERR_O,
  input  wire [15:0] MASTER_PERIOD_I,
  input  wire        PRI_SYNC_I,
  input  wire        SEC_SYNC_I,
  input  wire        MODULE_ENABLE_I,
  input  wire [1:0]  OUTPUT_MODE_I,
  input  wire        FAULT_I,
  input  wire        CURRENT_LIMIT_I,
  input  wire        TRIGGER_I,
  input  wire        DEADTIME_COMP_I,
  output wire        HIGH_OUTPUT_O,
  output wire        LOW_OUTPUT_O,
  output reg         FAULT_IRQ_O,
  output reg         CURRENT_LIMIT_IRQ_O,
  output reg         TRIGGER_IRQ_O
);

  localparam [15:0] ZONE_CYC = `PWMG_ZONE_CYC;
  localparam [15:0] MIN_P    = `PWMG_MIN_PULSE;

  // Fits a requested duty into what the generator can realise
  function [15:0] fit_duty;
    input [15:0] duty;
    input [15:0] per;
    input        center;
    reg   [15:0] v;
    reg   [15:0] hi;
    begin
      v  = duty;
      hi = (per > (MIN_P + MIN_P)) ? per - MIN_P : MIN_P;
      if (center)
        v = v & `PWMG_COARSE_MASK;
      if (v < MIN_P + ZONE_CYC || v + ZONE_CYC > hi)
        v = v & `PWMG_COARSE_MASK;
      if (duty == 16'h0000)
        fit_duty = 16'h0000;
      else if (v < MIN_P)
        fit_duty = MIN_P;
      else if (v > hi)
        fit_duty = hi;
      else
        fit_duty = v;
    end
  endfunction

  // Register file
  reg  [15:0] mst_reg;
  reg  [15:0] pdc_reg;
  reg  [15:0] sdc_reg;
  reg  [15:0] period_reg;
  reg  [15:0] ctl_reg;
  reg  [15:0] act_mst_reg;
  reg  [15:0] act_pdc_reg;
  reg  [15:0] act_sdc_reg;
  reg         fault_pend_reg;
  reg         curlim_pend_reg;
  reg         trig_pend_reg;

  // Pin synchronisers
  reg  [2:0]  fault_sync_reg;
  reg  [2:0]  curlim_sync_reg;
  reg  [1:0]  comp_sync_reg;

  // Time base
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg         down_reg;
  reg         down_next;
  reg         pp_phase_reg;
  reg         cycle_start;

  wire        wr_en   = PSEL_I & PENABLE_I & PWRITE_I;
  wire        wr_mst  = wr_en & (PADDR_I == `PWMG_OFS_MASTER_DUTY);
  wire        wr_ctl  = wr_en & (PADDR_I == `PWMG_OFS_CONTROL);
  wire        wr_pdc  = wr_en & (PADDR_I == `PWMG_OFS_PRIMARY_DUTY);
  wire        wr_sdc  = wr_en & (PADDR_I == `PWMG_OFS_SECONDARY_DUTY);
  wire        wr_per  = wr_en & (PADDR_I == `PWMG_OFS_LOCAL_PERIOD);
  wire [15:0] wdata   = PWDATA_I[15:0];
  wire [15:0] ctl_new = wr_ctl ? (wdata & `PWMG_CTL_WMASK) : ctl_reg;

  wire        local_period = ctl_reg[`PWMG_BIT_LOCAL_PERIOD];
  wire        shared_duty  = ctl_reg[`PWMG_BIT_SHARED_DUTY];
  wire [1:0]  dbc          = ctl_reg[`PWMG_BIT_DBC_HI:`PWMG_BIT_DBC_LO];
  wire        dbc_pol      = ctl_reg[`PWMG_BIT_DBC_POL];
  wire        tb_select    = ctl_reg[`PWMG_BIT_TB_SELECT];
  wire        immediate    = ctl_reg[`PWMG_BIT_IMMEDIATE];
  wire        ext_reset_en = ctl_reg[`PWMG_BIT_EXT_RESET];

  // Center alignment is ignored without a local period
  wire        center = ctl_reg[`PWMG_BIT_CENTER] & local_period;

  // Edge events and compensation level from synchronised pins
  wire        fault_evt  = fault_sync_reg[1] & ~fault_sync_reg[2];
  wire        curlim_evt = curlim_sync_reg[1] & ~curlim_sync_reg[2];
  wire        comp_in    = comp_sync_reg[1];

  // Period source
  wire [15:0] per_sel = local_period ? period_reg
                                     : MASTER_PERIOD_I;
  wire [15:0] period  = center ? (per_sel & `PWMG_COARSE_MASK)
                               : per_sel;

  // Secondary time base only where one is built
  wire        tb_sync = (tb_select && SEC_TB_PRESENT != 0) ? SEC_SYNC_I
                                                           : PRI_SYNC_I;
  wire        ext_restart = ext_reset_en & local_period & curlim_evt;

  // Duty sources
  wire [15:0] duty_h_sel = shared_duty ? act_mst_reg : act_pdc_reg;
  wire [15:0] duty_l_sel = shared_duty ? act_mst_reg : act_sdc_reg;
  wire [15:0] duty_h = fit_duty(duty_h_sel, period, center);
  wire [15:0] duty_l = fit_duty(duty_l_sel, period, center);

  wire        run     = MODULE_ENABLE_I;
  wire        below_h = run & (cnt_reg < duty_h);
  wire        below_l = run & (cnt_reg < duty_l);
  wire        indep   = (OUTPUT_MODE_I == `PWMG_MODE_INDEP);
  wire        compl   = (OUTPUT_MODE_I == `PWMG_MODE_COMPL);
  reg         raw_h;
  reg         raw_l;

  assign PREADY_O = 1'b1;

  // Time base counter; restarts on the selected time base sync unless local period
  always @*
  begin
    cnt_next    = cnt_reg;
    down_next   = down_reg;
    cycle_start = 1'b0;
    if (!run)
    begin
      cnt_next  = 16'h0000;
      down_next = 1'b0;
    end
    else if (ext_restart || (!local_period && tb_sync))
    begin
      cnt_next    = 16'h0000;
      down_next   = 1'b0;
      cycle_start = 1'b1;
    end
    else if (!center)
    begin
      if (cnt_reg + 16'h0001 >= period)
      begin
        cnt_next    = 16'h0000;
        cycle_start = 1'b1;
      end
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    else if (!down_reg)
    begin
      if (cnt_reg >= period)
      begin
        down_next = 1'b1;
        cnt_next  = (cnt_reg == 16'h0000) ? 16'h0000
                                          : cnt_reg - 16'h0001;
      end
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    else if (cnt_reg == 16'h0000)
    begin
      down_next   = 1'b0;
      cnt_next    = 16'h0001;
      cycle_start = 1'b1;
    end
    else
      cnt_next = cnt_reg - 16'h0001;
  end

  // Output mode steering
  always @*
  begin
    raw_h = below_h;
    raw_l = 1'b0;
    case (OUTPUT_MODE_I)
      `PWMG_MODE_INDEP:
        raw_l = below_l;
      `PWMG_MODE_COMPL:
        raw_l = run & ~below_h;
      `PWMG_MODE_REDUNDANT:
        raw_l = below_h;
      `PWMG_MODE_PUSHPULL:
      begin
        raw_h = below_h & ~pp_phase_reg;
        raw_l = below_h & pp_phase_reg;
      end
      default:
        raw_l = 1'b0;
    endcase
  end

  // Dead-time steering per output
  reg         short_h;
  reg         long_h;
  reg         short_l;
  reg         long_l;
  wire        comp_sel = comp_in ^ dbc_pol;

  always @*
  begin
    short_h = 1'b0;
    long_h  = 1'b0;
    short_l = 1'b0;
    long_l  = 1'b0;
    case (dbc)
      `PWMG_DBC_POSITIVE:
      begin
        short_h = 1'b1;
        short_l = 1'b1;
      end
      `PWMG_DBC_NEGATIVE:
      begin
        long_h = compl;
        long_l = compl;
      end
      `PWMG_DBC_OFF:
        short_h = 1'b0;
      `PWMG_DBC_COMP:
      begin
        short_h = ~comp_sel;
        long_l  = ~comp_sel;
        short_l = comp_sel;
        long_h  = comp_sel;
      end
      default:
        short_h = 1'b0;
    endcase
  end

  pwmg_edge_adj #(
    .DEAD_CYC   (DEAD_CYC)
  ) u_adj_high (
    .clk_i      (MCLK_I),
    .rst_n_i    (RST_N_I),
    .raw_i      (raw_h),
    .shorten_i  (short_h),
    .lengthen_i (long_h),
    .out_o      (HIGH_OUTPUT_O)
  );

  pwmg_edge_adj #(
    .DEAD_CYC   (DEAD_CYC)
  ) u_adj_low (
    .clk_i      (MCLK_I),
    .rst_n_i    (RST_N_I),
    .raw_i      (raw_l),
    .shorten_i  (short_l),
    .lengthen_i (long_l),
    .out_o      (LOW_OUTPUT_O)
  );

  // Registers, pending flags and time base state
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      mst_reg         <= `PWMG_RST_VALUE;
      pdc_reg         <= `PWMG_RST_VALUE;
      sdc_reg         <= `PWMG_RST_VALUE;
      period_reg      <= `PWMG_RST_VALUE;
      ctl_reg         <= `PWMG_RST_VALUE;
      act_mst_reg     <= `PWMG_RST_VALUE;
      act_pdc_reg     <= `PWMG_RST_VALUE;
      act_sdc_reg     <= `PWMG_RST_VALUE;
      fault_pend_reg  <= 1'b0;
      curlim_pend_reg <= 1'b0;
      trig_pend_reg   <= 1'b0;
      fault_sync_reg  <= 3'b000;
      curlim_sync_reg <= 3'b000;
      comp_sync_reg   <= 2'b00;
      cnt_reg         <= 16'h0000;
      down_reg        <= 1'b0;
      pp_phase_reg    <= 1'b0;
    end
    else
    begin
      fault_sync_reg  <= {fault_sync_reg[1:0], FAULT_I};
      curlim_sync_reg <= {curlim_sync_reg[1:0], CURRENT_LIMIT_I};
      comp_sync_reg   <= {comp_sync_reg[0], DEADTIME_COMP_I};
      cnt_reg         <= cnt_next;
      down_reg        <= down_next;
      if (!run)
        pp_phase_reg <= 1'b0;
      else if (cycle_start)
        pp_phase_reg <= ~pp_phase_reg;

      ctl_reg <= ctl_new;
      if (wr_mst)
        mst_reg <= wdata;
      if (wr_pdc)
        pdc_reg <= wdata;
      if (wr_sdc)
        sdc_reg <= wdata;
      if (wr_per)
        period_reg <= wdata;

      // Buffered duty loads at period start unless immediate
      if (wr_mst && immediate)
        act_mst_reg <= wdata;
      else if (cycle_start)
        act_mst_reg <= mst_reg;
      if (wr_pdc && immediate)
        act_pdc_reg <= wdata;
      else if (cycle_start)
        act_pdc_reg <= pdc_reg;
      if (wr_sdc && immediate)
        act_sdc_reg <= wdata;
      else if (cycle_start)
        act_sdc_reg <= sdc_reg;

      // Disabling an enable clears its flag, even over an event
      fault_pend_reg  <= ctl_new[`PWMG_BIT_FAULT_IEN] &
                         (fault_pend_reg | fault_evt);
      curlim_pend_reg <= ctl_new[`PWMG_BIT_CURLIM_IEN] &
                         (curlim_pend_reg | curlim_evt);
      trig_pend_reg   <= ctl_new[`PWMG_BIT_TRIG_IEN] &
                         (trig_pend_reg | TRIGGER_I);
    end
  end

  // Interrupt request levels follow the pending flags
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      FAULT_IRQ_O         <= 1'b0;
      CURRENT_LIMIT_IRQ_O <= 1'b0;
      TRIGGER_IRQ_O       <= 1'b0;
    end
    else
    begin
      FAULT_IRQ_O         <= fault_pend_reg;
      CURRENT_LIMIT_IRQ_O <= curlim_pend_reg;
      TRIGGER_IRQ_O       <= trig_pend_reg;
    end
  end

  // Read data captured in the setup phase; zero wait states
  reg  [31:0] rdata_next;
  reg         err_next;

  always @*
  begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (PADDR_I)
      `PWMG_OFS_MASTER_DUTY:
        rdata_next = {16'h0000, mst_reg};
      `PWMG_OFS_CONTROL:
        rdata_next = {16'h0000, fault_pend_reg, curlim_pend_reg,
                      trig_pend_reg, ctl_reg[12:0]};
      `PWMG_OFS_PRIMARY_DUTY:
        rdata_next = {16'h0000, pdc_reg};
      `PWMG_OFS_SECONDARY_DUTY:
        rdata_next = {16'h0000, sdc_reg};
      `PWMG_OFS_LOCAL_PERIOD:
        rdata_next = {16'h0000, period_reg};
      `PWMG_OFS_STATUS:
        rdata_next = {12'h000, pp_phase_reg, LOW_OUTPUT_O,
                      HIGH_OUTPUT_O, down_reg, cnt_reg};
      default:
        err_next = 1'b1;
    endcase
  end

  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
    else if (PSEL_I && !PENABLE_I)
    begin
      PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rdata_next;
      PSLVERR_O <= err_next;
    end
  end

endmodule // pwmg_top

`default_nettype wire

// File: hw/pwmg_status_note.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: verif/pwmg_stage.sv
`timescale 1ns/100ps
`default_nettype none
// Power stage: pin levels on command, conducting time per leg
module pwmg_stage (
  input  wire logic        clk_i,
  input  wire logic        high_i,
  input  wire logic        low_i,
  input  wire logic        win_i,
  input  wire logic        fault_cmd_i,
  input  wire logic        clim_cmd_i,
  input  wire logic        comp_cmd_i,
  output logic      [15:0] hi_cnt_o,
  output logic      [15:0] lo_cnt_o,
  output wire logic        fault_o,
  output wire logic        clim_o,
  output wire logic        comp_o
);
  // Counting whole periods makes the total independent of phase
  always @(posedge clk_i)
  begin
    hi_cnt_o <= win_i ? hi_cnt_o + {15'h0000, high_i} : 16'h0000;
    lo_cnt_o <= win_i ? lo_cnt_o + {15'h0000, low_i} : 16'h0000;
  end
  assign fault_o = fault_cmd_i;
  assign clim_o  = clim_cmd_i;
  assign comp_o  = comp_cmd_i;
endmodule // pwmg_stage
`default_nettype wire

// File: verif/pwmg_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_defs.vh"
module pwmg_top_sva #(
  parameter DEAD_CYC = 2
) (
  input wire logic        MCLK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        MODULE_ENABLE_I,
  input wire logic [1:0]  OUTPUT_MODE_I,
  input wire logic        TRIGGER_I,
  input wire logic        HIGH_OUTPUT_O,
  input wire logic        LOW_OUTPUT_O,
  input wire logic        FAULT_IRQ_O,
  input wire logic        CURRENT_LIMIT_IRQ_O,
  input wire logic        TRIGGER_IRQ_O
);
  logic [15:0] ctl_q;
  logic [1:0]  mode_q;
  logic [3:0]  age_q;
  logic [4:0]  off_q;
  wire         acc = PSEL_I && PENABLE_I;
  wire         ctl_wr = acc && PWRITE_I && PADDR_I == `PWMG_OFS_CONTROL;
  wire   [1:0] dbc = ctl_q[7:6];
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Age gates checks until delayed edges of an old setup are gone
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      ctl_q  <= 16'h0000;
      mode_q <= 2'h0;
      age_q  <= 4'h0;
      off_q  <= 5'h00;
    end
    else
    begin
      if (ctl_wr)
        ctl_q <= PWDATA_I[15:0] & `PWMG_CTL_WMASK;
      mode_q <= OUTPUT_MODE_I;
      age_q  <= (ctl_wr || mode_q != OUTPUT_MODE_I) ? 4'h0 :
                age_q + {3'h0, age_q != 4'hf};
      off_q  <= MODULE_ENABLE_I ? 5'h00 : off_q + {4'h0, off_q != 5'h1f};
    end
  end
  ctl_readback_a: assert property (
    acc && !PWRITE_I && PADDR_I == `PWMG_OFS_CONTROL |->
    PRDATA_O[31:16] == 16'h0000 && PRDATA_O[12:0] == ctl_q[12:0])
    else $error("control readback wrong");
  fault_clear_a: assert property (
    ctl_wr && !PWDATA_I[12] |=> ##1 !FAULT_IRQ_O)
    else $error("fault request kept after disable");
  clim_clear_a: assert property (
    ctl_wr && !PWDATA_I[11] |=> ##1 !CURRENT_LIMIT_IRQ_O)
    else $error("limit request kept after disable");
  trig_clear_a: assert property (
    ctl_wr && !PWDATA_I[10] |=> ##1 !TRIGGER_IRQ_O)
    else $error("trigger request kept after disable");
  trig_set_a: assert property (
    TRIGGER_I && ctl_q[10] && !ctl_wr |=> ##1 TRIGGER_IRQ_O)
    else $error("trigger request missing");
  trig_gate_a: assert property (
    TRIGGER_IRQ_O |-> $past(ctl_q[10]))
    else $error("trigger request while disabled");
  idle_quiet_a: assert property (
    off_q > 5'(DEAD_CYC + 2) |-> !HIGH_OUTPUT_O && !LOW_OUTPUT_O)
    else $error("output active while disabled");
  dead_band_a: assert property (
    OUTPUT_MODE_I == `PWMG_MODE_COMPL && dbc == `PWMG_DBC_POSITIVE &&
    age_q > 4'h7 |-> !(HIGH_OUTPUT_O && LOW_OUTPUT_O))
    else $error("both outputs on with dead time");
  compl_pair_a: assert property (
    MODULE_ENABLE_I [*3] ##0 (OUTPUT_MODE_I == `PWMG_MODE_COMPL &&
    dbc == `PWMG_DBC_OFF && age_q > 4'h7) |-> HIGH_OUTPUT_O != LOW_OUTPUT_O)
    else $error("outputs not complementary");
  fault_c: cover property (FAULT_IRQ_O);
  clim_c: cover property (CURRENT_LIMIT_IRQ_O);
  trig_c: cover property (TRIGGER_IRQ_O);
endmodule // pwmg_top_sva
bind pwmg_top pwmg_top_sva #(.DEAD_CYC(DEAD_CYC)) u_sva (.MCLK_I, .RST_N_I,
  .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
  .MODULE_ENABLE_I, .OUTPUT_MODE_I, .TRIGGER_I, .HIGH_OUTPUT_O,
  .LOW_OUTPUT_O, .FAULT_IRQ_O, .CURRENT_LIMIT_IRQ_O, .TRIGGER_IRQ_O);
`default_nettype wire

// File: verif/pwmg_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_defs.vh"
module pwmg_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] per = 16'h0028;
  logic        pri = 1'b0;
  logic        sec = 1'b0;
  logic        en = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  ev = 3'h0;
  logic        comp = 1'b0;
  logic        win = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, hi, lo, flt, clm, cmpi;
  wire  [2:0]  irq;
  wire  [15:0] hcnt, lcnt;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  pwmg_top DUT (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MASTER_PERIOD_I(per), .PRI_SYNC_I(pri), .SEC_SYNC_I(sec),
    .MODULE_ENABLE_I(en), .OUTPUT_MODE_I(mode), .FAULT_I(flt),
    .CURRENT_LIMIT_I(clm), .TRIGGER_I(ev[0]), .DEADTIME_COMP_I(cmpi),
    .HIGH_OUTPUT_O(hi), .LOW_OUTPUT_O(lo), .FAULT_IRQ_O(irq[2]),
    .CURRENT_LIMIT_IRQ_O(irq[1]), .TRIGGER_IRQ_O(irq[0]));
  pwmg_stage stage (.clk_i(clk), .high_i(hi), .low_i(lo), .win_i(win),
    .fault_cmd_i(ev[2]), .clim_cmd_i(ev[1]), .comp_cmd_i(comp),
    .hi_cnt_o(hcnt), .lo_cnt_o(lcnt), .fault_o(flt), .clim_o(clm),
    .comp_o(cmpi));
  always #5 clk = ~clk;
  // Secondary time base runs at twice the primary rate
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pri <= cyc % 40 == 39;
    sec <= cyc % 20 == 19;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 40)
      n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 16'h0000, q, e);
    cmp(q, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask
  task automatic pulse(input int i);
    ev <= 3'h1 << i;
    @(posedge clk);
    ev <= 3'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic run(input logic [15:0] c, input logic [1:0] m,
    input logic [15:0] d, input logic [15:0] s, output logic [15:0] h,
    output logic [15:0] l);
    // Mode bits change only while the module is disabled
    en <= 1'b0;
    mode <= m;
    wr(`PWMG_OFS_CONTROL, c);
    wr(`PWMG_OFS_PRIMARY_DUTY, d);
    wr(`PWMG_OFS_SECONDARY_DUTY, s);
    en <= 1'b1;
    repeat (80) @(posedge clk);
    win <= 1'b1;
    repeat (160) @(posedge clk);
    win <= 1'b0;
    // Counts settled between edges, before the window clears them
    @(negedge clk);
    h = hcnt;
    l = lcnt;
    @(posedge clk);
  endtask
  task automatic duty(input logic [15:0] c, input logic [1:0] m,
    input logic [15:0] d, input logic [15:0] s, input logic [15:0] xh,
    input logic [15:0] xl);
    logic [15:0] h, l;
    run(c, m, d, s, h, l);
    cmp({h, l}, {xh, xl});
  endtask
  // Dead-time effect judged against the plain 80-cycle high time
  task automatic dt(input logic [15:0] c, input logic cp,
    input logic [1:0] x);
    logic [15:0] h, l;
    comp <= cp;
    run(c, 2'h0, 16'h0014, 16'h0000, h, l);
    cmp({30'h0, h < 16'h0050, h > 16'h0050}, {30'h0, x});
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    wrap_up;
  end
  initial
  begin
    logic [31:0] q;
    logic        e;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4)
      rd(8'(a), 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    wr(`PWMG_OFS_CONTROL, 16'hffff);
    rd(`PWMG_OFS_CONTROL, 32'h1fef, 1'b0);
    wr(`PWMG_OFS_MASTER_DUTY, 16'h000e);
    rd(`PWMG_OFS_MASTER_DUTY, 32'he, 1'b0);
    wr(`PWMG_OFS_LOCAL_PERIOD, 16'h0020);
    for (int i = 0; i < 3; i++)
    begin
      wr(`PWMG_OFS_CONTROL, 16'h0000);
      pulse(i);
      rd(`PWMG_OFS_CONTROL, 32'h0, 1'b0);
      wr(`PWMG_OFS_CONTROL, 16'h0400 << i);
      pulse(i);
      rd(`PWMG_OFS_CONTROL, {16'h0, 16'h2400 << i}, 1'b0);
      cmp({29'h0, irq}, 32'h1 << i);
      wr(`PWMG_OFS_CONTROL, 16'h0000);
      rd(`PWMG_OFS_CONTROL, 32'h0, 1'b0);
      cmp({29'h0, irq}, 32'h0);
    end
    en <= 1'b1;
    duty(16'h0081, 2'h0, 16'h0014, 16'h0, 16'h0050, 16'h0050);
    duty(16'h0085, 2'h0, 16'h0014, 16'h0, 16'h0050, 16'h0050);
    duty(16'h0081, 2'h0, 16'h0003, 16'h0, 16'h0024, 16'h007c);
    duty(16'h0081, 2'h0, 16'h0026, 16'h0, 16'h007c, 16'h0024);
    duty(16'h0181, 2'h0, 16'h0014, 16'h0, 16'h0038, 16'h0068);
    duty(16'h0089, 2'h0, 16'h000e, 16'h0, 16'h0070, 16'h0030);
    duty(16'h0081, 2'h3, 16'h0014, 16'hf, 16'h0050, 16'h003c);
    duty(16'h0281, 2'h0, 16'h0010, 16'h0, 16'h0050, 16'h0050);
    duty(16'h0080, 2'h0, 16'h0014, 16'h0, 16'h0050, 16'h0050);
    dt(16'h0001, 1'b0, 2'h2);
    dt(16'h0041, 1'b0, 2'h1);
    dt(16'h00a1, 1'b1, 2'h0);
    dt(16'h00c1, 1'b0, 2'h2);
    dt(16'h00c1, 1'b1, 2'h1);
    dt(16'h00e1, 1'b0, 2'h1);
    dt(16'h00e1, 1'b1, 2'h2);
    // Limit edge restarts the local count: six edges later it reads 6
    en <= 1'b0;
    wr(`PWMG_OFS_CONTROL, 16'h0283);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(1);
    xfer(1'b0, `PWMG_OFS_STATUS, 16'h0000, q, e);
    cmp({16'h0, q[15:0]}, 32'h6);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    cmp({30'h0, hi, lo}, 32'h0);
    wrap_up;
  end
endmodule // pwmg_top_tb
`default_nettype wire
